// ### rtl/mdfp_fault_protect.sv
// fault detection and bridge response of the three-phase driver protection block
module mdfp_fault_protect
    import mdfp_pkg::*;
#(
    parameter int OC_RETRY_CYCLES = mdfp_pkg::OC_RETRY_CYCLES_DEF,
    parameter int LOCK_RETRY_CYCLES = mdfp_pkg::LOCK_RETRY_CYCLES_DEF
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    input wire logic [mdfp_pkg::ADDR_W-1:0] regAddr,
    input wire logic [mdfp_pkg::DATA_W-1:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [mdfp_pkg::DATA_W-1:0] regRdata,
    input wire logic analogSupplyUv,
    input wire logic buckFeedbackUv,
    input wire logic chargePumpUv,
    input wire logic supplyOverLow,
    input wire logic supplyOverHigh,
    input wire logic buckOverCurrent,
    input wire logic [mdfp_pkg::FET_N-1:0] fetOverCurrent,
    input wire logic [mdfp_pkg::PHASE_N-1:0] phaseOverLockLimit,
    input wire logic adcValid,
    input wire logic [mdfp_pkg::SMP_W-1:0] adcPhaseA,
    input wire logic [mdfp_pkg::SMP_W-1:0] adcPhaseB,
    input wire logic [mdfp_pkg::SMP_W-1:0] adcPhaseC,
    input wire logic faultPinInN,
    output logic faultPinOutN,
    output logic faultPinOeN,
    output logic fetsOff,
    output logic lowSideOn,
    output logic highSideOn,
    output logic chargePumpEnable,
    output logic controllerEnable,
    output logic resetRequest,
    output logic buckHiZ,
    output logic [mdfp_pkg::LVL_W-1:0] fetOvercurrentLevel,
    output logic [mdfp_pkg::LVL_W-1:0] comparatorLockCurrentLimit
);
    import mdfp_pkg::*;

    typedef struct packed {
        logic [SYNC_W-1:0] syncA;
        logic [SYNC_W-1:0] syncB;
        logic [CFG_W-1:0] cfg;
        logic [DEG_REG_W-1:0] deg;
        logic [SMP_W-1:0] lim;
        logic smpExceed;
        mdfp_oc_st_t ocSt;
        logic [RETRY_W-1:0] ocCnt;
        mdfp_lock_st_t [LOCK_N-1:0] lockSt;
        mdfp_act_t [LOCK_N-1:0] lockAct;
        logic [LOCK_N-1:0][RETRY_W-1:0] lockCnt;
        logic chargePumpUvFlag;
        logic overvoltageFlag;
        logic overcurrentFlag;
        logic buckUvFlag;
        logic buckOcTrip;
        logic [FET_N-1:0] fetOcFlags;
        logic driverFault;
        logic controllerFault;
        logic fetsOff;
        logic lowSideOn;
        logic highSideOn;
        logic cpEnable;
        logic ctlEnable;
        logic rstRequest;
        logic [DATA_W-1:0] rdata;
    } mdfp_state_t;

    mdfp_state_t st_ff;
    mdfp_state_t nxt_st;

    logic [FET_N-1:0] fetOcDeg;
    logic buckOcDeg;
    logic [LOCK_N-1:0] lockTrip;
    logic [LOCK_N-1:0][2:0] lockMode;
    logic clearCmd;
    logic ovCond;
    logic [SYNC_W-1:0] pinVec;

    assign pinVec = {faultPinInN, phaseOverLockLimit, fetOverCurrent, buckOverCurrent,
        supplyOverHigh, supplyOverLow, chargePumpUv, buckFeedbackUv, analogSupplyUv};
    assign clearCmd = regWrite && regAddr == CTRL_OFS && regWdata[CTRL_CLEAR_BIT];
    assign ovCond = st_ff.cfg[CFG_OV_EN_BIT] && (st_ff.cfg[CFG_OV_SEL_BIT] ?
        st_ff.syncB[SY_OV_HI] : st_ff.syncB[SY_OV_LO]);
    assign lockMode[LK_CMP] = st_ff.cfg[CFG_CMP_MODE_LSB +: 3];
    assign lockMode[LK_SMP] = st_ff.cfg[CFG_SMP_MODE_LSB +: 3];

    // per-FET filters share one deglitch setting, as the FETs share one threshold
    for (genvar f = 0; f < FET_N; f++) begin : g_fet_deg
        mdfp_deglitch #(.CNT_W(DEG_W)) u_fet_deg (
            .clock(clock),
            .rst(rst),
            .ce(ce),
            .level(st_ff.syncB[SY_FOC + f]),
            .limit(st_ff.deg[OC_DEG_LSB +: DEG_W]),
            .tripped(fetOcDeg[f])
        );
    end

    mdfp_deglitch #(.CNT_W(DEG_W)) u_buck_deg (
        .clock(clock),
        .rst(rst),
        .ce(ce),
        .level(st_ff.syncB[SY_BOC]),
        .limit(st_ff.deg[OC_DEG_LSB +: DEG_W]),
        .tripped(buckOcDeg)
    );

    mdfp_deglitch #(.CNT_W(DEG_W)) u_cmp_deg (
        .clock(clock),
        .rst(rst),
        .ce(ce),
        .level(|st_ff.syncB[SY_PLK +: PHASE_N]),
        .limit(st_ff.deg[CMP_DEG_LSB +: DEG_W]),
        .tripped(lockTrip[LK_CMP])
    );

    mdfp_deglitch #(.CNT_W(DEG_W)) u_smp_deg (
        .clock(clock),
        .rst(rst),
        .ce(ce),
        .level(st_ff.smpExceed),
        .limit(st_ff.deg[SMP_DEG_LSB +: DEG_W]),
        .tripped(lockTrip[LK_SMP])
    );

    always_comb begin
        logic anyOff;
        logic anyLow;
        logic anyHigh;
        logic auv;
        logic cpuv;
        anyOff = 1'h0;
        anyLow = 1'h0;
        anyHigh = 1'h0;
        nxt_st = st_ff;
        auv = st_ff.syncB[SY_AUV];
        cpuv = st_ff.syncB[SY_CPUV];
        nxt_st.syncA = pinVec;
        nxt_st.syncB = st_ff.syncA;
        nxt_st.rdata = '0;
        if (regWrite) begin
            case (regAddr)
                CFG_OFS: nxt_st.cfg = regWdata[CFG_W-1:0];
                DEG_OFS: nxt_st.deg = regWdata[DEG_REG_W-1:0];
                LIM_OFS: nxt_st.lim = regWdata[SMP_W-1:0];
                default: ;
            endcase
        end
        if (regRead) begin
            case (regAddr)
                CFG_OFS: nxt_st.rdata = DATA_W'(st_ff.cfg);
                DEG_OFS: nxt_st.rdata = DATA_W'(st_ff.deg);
                LIM_OFS: nxt_st.rdata = DATA_W'(st_ff.lim);
                STAT_OFS: begin
                    nxt_st.rdata[ST_DRV_FLT] = st_ff.driverFault;
                    nxt_st.rdata[ST_CTL_FLT] = st_ff.controllerFault;
                    nxt_st.rdata[ST_CP_UV] = st_ff.chargePumpUvFlag;
                    nxt_st.rdata[ST_OV] = st_ff.overvoltageFlag;
                    nxt_st.rdata[ST_OC] = st_ff.overcurrentFlag;
                    nxt_st.rdata[ST_BUCK_UV] = st_ff.buckUvFlag;
                    nxt_st.rdata[ST_CMP_LOCK] = st_ff.lockSt[LK_CMP] != LK_IDLE;
                    nxt_st.rdata[ST_SMP_LOCK] = st_ff.lockSt[LK_SMP] != LK_IDLE;
                    nxt_st.rdata[ST_BUCK_OC] = st_ff.buckOcTrip;
                    nxt_st.rdata[ST_FET_OC_LSB +: FET_N] = st_ff.fetOcFlags;
                    nxt_st.rdata[ST_PIN] = st_ff.syncB[SY_PIN];
                end
                default: ;
            endcase
        end
        // samples are compared as they arrive; the level holds between samples
        if (adcValid) begin
            nxt_st.smpExceed = adcPhaseA > st_ff.lim || adcPhaseB > st_ff.lim ||
                adcPhaseC > st_ff.lim;
        end
        // set wins over a clear arriving in the same cycle
        nxt_st.chargePumpUvFlag = cpuv || (st_ff.chargePumpUvFlag && !clearCmd);
        nxt_st.overvoltageFlag = ovCond || (st_ff.overvoltageFlag && !clearCmd);
        nxt_st.overcurrentFlag = (|fetOcDeg) || (st_ff.overcurrentFlag && !clearCmd);
        nxt_st.fetOcFlags = fetOcDeg | (st_ff.fetOcFlags & ~{FET_N{clearCmd}});
        nxt_st.buckUvFlag = st_ff.syncB[SY_BUV];
        // buck overcurrent stands until the device reset it requested
        nxt_st.buckOcTrip = st_ff.buckOcTrip || buckOcDeg;
        case (st_ff.ocSt)
            OC_IDLE: begin
                if (|fetOcDeg) begin
                    if (st_ff.cfg[CFG_OC_MODE_LSB +: 2] == OC_MODE_RETRY) begin
                        nxt_st.ocSt = OC_RETRY;
                        nxt_st.ocCnt = RETRY_W'(OC_RETRY_CYCLES - 1);
                    end else begin
                        nxt_st.ocSt = OC_LATCH;
                    end
                end
            end
            OC_LATCH: begin
                if (clearCmd && !(|st_ff.syncB[SY_FOC +: FET_N])) begin
                    nxt_st.ocSt = OC_IDLE;
                end
            end
            OC_RETRY: begin
                if (st_ff.ocCnt == '0) begin
                    nxt_st.ocSt = OC_IDLE;
                end else begin
                    nxt_st.ocCnt = st_ff.ocCnt - RETRY_W'(1);
                end
            end
            default: nxt_st.ocSt = OC_IDLE;
        endcase
        for (int i = 0; i < LOCK_N; i++) begin
            case (st_ff.lockSt[i])
                LK_IDLE: begin
                    if (lockTrip[i]) begin
                        case (lockMode[i])
                            LKM_LATCH_OFF, LKM_LATCH_LOW, LKM_LATCH_HIGH:
                                nxt_st.lockSt[i] = LK_LATCH;
                            LKM_RETRY_OFF, LKM_RETRY_LOW, LKM_RETRY_HIGH: begin
                                nxt_st.lockSt[i] = LK_RETRY;
                                nxt_st.lockCnt[i] = RETRY_W'(LOCK_RETRY_CYCLES - 1);
                            end
                            LKM_REPORT: nxt_st.lockSt[i] = LK_REPORT;
                            default: ;
                        endcase
                        case (lockMode[i])
                            LKM_LATCH_OFF, LKM_RETRY_OFF: nxt_st.lockAct[i] = ACT_OFF;
                            LKM_LATCH_LOW, LKM_RETRY_LOW: nxt_st.lockAct[i] = ACT_LOW;
                            LKM_LATCH_HIGH, LKM_RETRY_HIGH: nxt_st.lockAct[i] = ACT_HIGH;
                            default: nxt_st.lockAct[i] = ACT_NONE;
                        endcase
                    end
                end
                LK_LATCH, LK_REPORT: begin
                    if (clearCmd && !lockTrip[i]) begin
                        nxt_st.lockSt[i] = LK_IDLE;
                    end
                end
                LK_RETRY: begin
                    if (st_ff.lockCnt[i] == '0) begin
                        nxt_st.lockSt[i] = LK_IDLE;
                    end else begin
                        nxt_st.lockCnt[i] = st_ff.lockCnt[i] - RETRY_W'(1);
                    end
                end
                default: nxt_st.lockSt[i] = LK_IDLE;
            endcase
            if (nxt_st.lockSt[i] == LK_LATCH || nxt_st.lockSt[i] == LK_RETRY) begin
                anyOff = anyOff || nxt_st.lockAct[i] == ACT_OFF;
                anyLow = anyLow || nxt_st.lockAct[i] == ACT_LOW;
                anyHigh = anyHigh || nxt_st.lockAct[i] == ACT_HIGH;
            end
        end
        nxt_st.driverFault = cpuv || ovCond || nxt_st.ocSt != OC_IDLE;
        nxt_st.controllerFault = nxt_st.lockSt[LK_CMP] != LK_IDLE ||
            nxt_st.lockSt[LK_SMP] != LK_IDLE;
        anyOff = anyOff || auv || nxt_st.buckOcTrip || nxt_st.driverFault;
        // opposing lock actions at once fall back to all off rather than shoot-through
        nxt_st.fetsOff = anyOff || (anyLow && anyHigh);
        nxt_st.lowSideOn = !nxt_st.fetsOff && anyLow;
        nxt_st.highSideOn = !nxt_st.fetsOff && anyHigh;
        nxt_st.cpEnable = !auv;
        nxt_st.ctlEnable = !auv;
        nxt_st.rstRequest = auv || nxt_st.buckOcTrip;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            st_ff <= '0;
            st_ff.cfg <= CFG_RESET;
            st_ff.deg <= DEG_RESET;
            st_ff.lim <= LIM_RESET;
            st_ff.fetsOff <= 1'h1;
            st_ff.cpEnable <= 1'h1;
            st_ff.ctlEnable <= 1'h1;
        end else if (ce) begin
            st_ff <= nxt_st;
        end
    end

    assign regRdata = st_ff.rdata;
    assign faultPinOutN = 1'h0;
    assign faultPinOeN = !(st_ff.driverFault || st_ff.controllerFault);
    assign fetsOff = st_ff.fetsOff;
    assign lowSideOn = st_ff.lowSideOn;
    assign highSideOn = st_ff.highSideOn;
    assign chargePumpEnable = st_ff.cpEnable;
    assign controllerEnable = st_ff.ctlEnable;
    assign resetRequest = st_ff.rstRequest;
    assign buckHiZ = st_ff.buckOcTrip;
    assign fetOvercurrentLevel = st_ff.cfg[CFG_OC_LVL_LSB +: LVL_W];
    assign comparatorLockCurrentLimit = st_ff.cfg[CFG_CMP_LIM_LSB +: LVL_W];

    default clocking @(posedge clock); endclocking
    default disable iff (rst);

    a_supply_uv_off: assert property (
        ce && st_ff.syncB[SY_AUV] |=> resetRequest && fetsOff && !chargePumpEnable
        && !controllerEnable) else $error("analog undervoltage did not shut down");
    a_buck_uv_flag: assert property (
        ce && st_ff.syncB[SY_BUV] && !st_ff.buckOcTrip && !buckOcDeg |=> st_ff.buckUvFlag
        && !buckHiZ) else $error("buck undervoltage flag or regulation wrong");
    a_cp_uv_trip: assert property (
        ce && st_ff.syncB[SY_CPUV] |=> fetsOff && !faultPinOeN && st_ff.driverFault
        && st_ff.chargePumpUvFlag) else $error("charge pump undervoltage response missing");
    a_cp_flag_hold: assert property (
        ce && st_ff.chargePumpUvFlag && !clearCmd |=> st_ff.chargePumpUvFlag)
        else $error("charge pump flag dropped without clear");
    a_ov_level_pick: assert property (
        ce && st_ff.cfg[CFG_OV_EN_BIT] && (st_ff.cfg[CFG_OV_SEL_BIT] ? st_ff.syncB[SY_OV_HI]
        : st_ff.syncB[SY_OV_LO]) |=> st_ff.overvoltageFlag && fetsOff)
        else $error("overvoltage not acted on");
    a_oc_latch_hold: assert property (
        ce && st_ff.ocSt == OC_LATCH && !clearCmd |=> st_ff.ocSt == OC_LATCH && fetsOff)
        else $error("latched overcurrent released without clear");
    a_oc_retry_end: assert property (
        ce && st_ff.ocSt == OC_RETRY && st_ff.ocCnt == '0 && !(|fetOcDeg)
        && !st_ff.syncB[SY_CPUV] && !ovCond && st_ff.overcurrentFlag && !clearCmd
        |=> st_ff.ocSt == OC_IDLE && !st_ff.driverFault && st_ff.overcurrentFlag)
        else $error("overcurrent retry end wrong");
    a_buck_oc_trip: assert property (
        ce && buckOcDeg |=> buckHiZ && resetRequest) else $error("buck overcurrent ignored");
    a_cmp_report: assert property (
        ce && st_ff.lockSt[LK_CMP] == LK_IDLE && lockTrip[LK_CMP]
        && lockMode[LK_CMP] == LKM_REPORT |=> st_ff.controllerFault && !faultPinOeN
        && st_ff.lockAct[LK_CMP] == ACT_NONE) else $error("report mode lock wrong");
    a_cmp_disabled: assert property (
        ce && lockMode[LK_CMP] == LKM_DISABLED && st_ff.lockSt[LK_CMP] == LK_IDLE
        |=> st_ff.lockSt[LK_CMP] == LK_IDLE) else $error("disabled lock mode acted");
    a_smp_retry_end: assert property (
        ce && st_ff.lockSt[LK_SMP] == LK_RETRY && st_ff.lockCnt[LK_SMP] == '0
        |=> st_ff.lockSt[LK_SMP] == LK_IDLE) else $error("sampled lock retry did not end");
    a_pin_follow: assert property (
        ce && !st_ff.syncB[SY_CPUV] && !ovCond && st_ff.ocSt == OC_IDLE && !(|fetOcDeg)
        && st_ff.lockSt[LK_CMP] == LK_IDLE && st_ff.lockSt[LK_SMP] == LK_IDLE && !(|lockTrip)
        |=> faultPinOeN) else $error("fault pin held with no fault left");

    c_oc_retry: cover property (st_ff.ocSt == OC_RETRY ##1 st_ff.ocSt == OC_IDLE);
    c_cmp_latch: cover property (st_ff.lockSt[LK_CMP] == LK_LATCH && lowSideOn);
    c_smp_high: cover property (st_ff.lockSt[LK_SMP] == LK_RETRY && highSideOn);
    c_cp_uv: cover property (st_ff.chargePumpUvFlag && !st_ff.syncB[SY_CPUV]);
endmodule : mdfp_fault_protect

// ### shared/mdfp_pkg.sv
// register map, field layout, timing constants and types of the fault protection block
// Overview of operation
// - analog supply undervoltage disables FETs, charge pump, controller and requests reset.
// - buck feedback undervoltage raises a flag; the buck keeps regulating.
// - charge pump undervoltage turns FETs off, pulls pin, flag sticks until clear.
// - enabled overvoltage turns FETs off, pulls pin, flag sticks until clear.
// - overvoltage threshold is the low or high comparator, picked by level select.
// - FET overcurrent counts only after outlasting the programmed deglitch time.
// - latched overcurrent holds FETs off until condition gone and clear issued.
// - retry overcurrent resumes after retry time; overcurrent flags wait for clear.
// - deglitched buck high-side overcurrent floats the buck and requests reset.
// - any phase over comparator lock limit past its deglitch is an event.
// - comparator lock latched modes pick bridge state, resume after clear.
// - comparator lock retry modes pick bridge state, resume after lock retry time.
// - comparator lock report mode flags only; flags leave after clear.
// - comparator lock disabled mode ignores the event entirely.
// - any ADC phase sample over sampled lock limit past its deglitch is an event.
// - sampled lock latched modes pick bridge state, resume after clear.
// - sampled lock retry modes resume and drop flags after lock retry time.
// - sampled lock report mode flags only; flags leave after clear.
// - sampled lock disabled mode ignores the event entirely.
package mdfp_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
    localparam logic [ADDR_W-1:0] CFG_OFS = 8'h04;
    localparam logic [ADDR_W-1:0] DEG_OFS = 8'h08;
    localparam logic [ADDR_W-1:0] LIM_OFS = 8'h0c;
    localparam logic [ADDR_W-1:0] STAT_OFS = 8'h10;
    localparam int CTRL_CLEAR_BIT = 0;
    // config register fields
    localparam int CFG_OV_EN_BIT = 0;
    localparam int CFG_OV_SEL_BIT = 1;
    localparam int CFG_OC_MODE_LSB = 2;
    localparam int CFG_CMP_MODE_LSB = 4;
    localparam int CFG_SMP_MODE_LSB = 7;
    localparam int CFG_OC_LVL_LSB = 10;
    localparam int CFG_CMP_LIM_LSB = 14;
    localparam int LVL_W = 4;
    localparam int CFG_W = 18;
    localparam logic [CFG_W-1:0] CFG_RESET = 18'h00001;
    // deglitch register fields, counts in clock cycles
    localparam int DEG_W = 8;
    localparam int OC_DEG_LSB = 0;
    localparam int CMP_DEG_LSB = 8;
    localparam int SMP_DEG_LSB = 16;
    localparam int DEG_REG_W = 24;
    localparam logic [DEG_REG_W-1:0] DEG_RESET = 24'h0a0a0a;
    localparam int SMP_W = 12;
    localparam logic [SMP_W-1:0] LIM_RESET = 12'h800;
    // status register bits
    localparam int ST_DRV_FLT = 0;
    localparam int ST_CTL_FLT = 1;
    localparam int ST_CP_UV = 2;
    localparam int ST_OV = 3;
    localparam int ST_OC = 4;
    localparam int ST_BUCK_UV = 5;
    localparam int ST_CMP_LOCK = 6;
    localparam int ST_SMP_LOCK = 7;
    localparam int ST_BUCK_OC = 8;
    localparam int ST_FET_OC_LSB = 9;
    localparam int ST_PIN = 15;
    // synchroniser slots of the analog comparator and pin inputs
    localparam int FET_N = 6;
    localparam int PHASE_N = 3;
    localparam int SY_AUV = 0;
    localparam int SY_BUV = 1;
    localparam int SY_CPUV = 2;
    localparam int SY_OV_LO = 3;
    localparam int SY_OV_HI = 4;
    localparam int SY_BOC = 5;
    localparam int SY_FOC = 6;
    localparam int SY_PLK = 12;
    localparam int SY_PIN = 15;
    localparam int SYNC_W = 16;
    // modes
    localparam logic [1:0] OC_MODE_LATCH = 2'h0;
    localparam logic [1:0] OC_MODE_RETRY = 2'h1;
    localparam logic [2:0] LKM_LATCH_OFF = 3'h0;
    localparam logic [2:0] LKM_LATCH_LOW = 3'h1;
    localparam logic [2:0] LKM_LATCH_HIGH = 3'h2;
    localparam logic [2:0] LKM_RETRY_OFF = 3'h3;
    localparam logic [2:0] LKM_RETRY_LOW = 3'h4;
    localparam logic [2:0] LKM_RETRY_HIGH = 3'h5;
    localparam logic [2:0] LKM_REPORT = 3'h6;
    localparam logic [2:0] LKM_DISABLED = 3'h7;
    localparam int LOCK_N = 2;
    localparam int LK_CMP = 0;
    localparam int LK_SMP = 1;
    // timing
    localparam int CLOCK_MHZ = 100;
    localparam int OC_RETRY_TIME_US = 500;
    localparam int LOCK_RETRY_TIME_US = 1000;
    localparam int OC_RETRY_CYCLES_DEF = OC_RETRY_TIME_US * CLOCK_MHZ;
    localparam int LOCK_RETRY_CYCLES_DEF = LOCK_RETRY_TIME_US * CLOCK_MHZ;
    localparam int RETRY_W = 20;
    typedef enum logic [1:0] {LK_IDLE = 2'b00, LK_LATCH = 2'b01, LK_RETRY = 2'b10,
        LK_REPORT = 2'b11} mdfp_lock_st_t;
    typedef enum logic [1:0] {OC_IDLE = 2'b00, OC_LATCH = 2'b01, OC_RETRY = 2'b10} mdfp_oc_st_t;
    typedef enum logic [1:0] {ACT_NONE = 2'b00, ACT_OFF = 2'b01, ACT_LOW = 2'b10,
        ACT_HIGH = 2'b11} mdfp_act_t;
endpackage : mdfp_pkg

// ### rtl/mdfp_deglitch.sv
// deglitch filter: output rises once the level has outlasted the programmed count
module mdfp_deglitch #(
    parameter int CNT_W = 8
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    input wire logic level,
    input wire logic [CNT_W-1:0] limit,
    output logic tripped
);
    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic tripped;
    } mdfp_deg_state_t;

    mdfp_deg_state_t st_ff;
    mdfp_deg_state_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        if (!level) begin
            nxt_st.cnt = '0;
            nxt_st.tripped = 1'h0;
        end else if (st_ff.cnt >= limit) begin
            nxt_st.tripped = 1'h1;
        end else begin
            nxt_st.cnt = st_ff.cnt + CNT_W'(1);
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            st_ff <= '0;
        end else if (ce) begin
            st_ff <= nxt_st;
        end
    end

    assign tripped = st_ff.tripped;

    a_deg_drop: assert property (@(posedge clock) disable iff (rst)
        ce && !level |=> !tripped) else $error("deglitch output held after level fell");
    a_deg_early: assert property (@(posedge clock) disable iff (rst)
        ce && level && !tripped && st_ff.cnt < limit |=> !tripped)
        else $error("deglitch output rose before count reached");
endmodule : mdfp_deglitch

// ### bench/mdfp_host_model.sv
// host side of the open-drain fault line and its pull-up
module mdfp_host_model (
    input wire logic faultPinOutN,
    input wire logic faultPinOeN,
    output logic pinLevelN
);
    timeunit 1ns;
    timeprecision 1ps;
    // a released line is pulled up, so it never shows the last driven level
    assign pinLevelN = faultPinOeN ? 1'b1 : faultPinOutN;
endmodule : mdfp_host_model

// ### bench/mdfp_fault_protect_tb.sv
// self-checking bench of the motor driver fault protection block
module mdfp_fault_protect_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import mdfp_pkg::*;
    logic clock = 0, rst = 1, rdS = 0, wrS = 0, auv = 0, fOc = 0, cLk = 0, sLk = 0;
    logic ceIn = 1, buv = 0, boc = 0, hiZ;
    logic [3:0] ocLvl, lkLim;
    logic [2:0] sup = 0;
    logic [7:0] addr = 0;
    logic [31:0] wd = 0, rdat;
    logic oeN, outN, pinN, fOff, lowOn, highOn, cpEn, ctlEn, rstReq;
    int nFail = 0, cmpCount = 0;
    mdfp_fault_protect #(.OC_RETRY_CYCLES(20), .LOCK_RETRY_CYCLES(30)) mdfp_fault_protect_i (
        .clock(clock), .rst(rst), .ce(ceIn), .regAddr(addr), .regWdata(wd), .regWrite(wrS),
        .regRead(rdS), .regRdata(rdat), .analogSupplyUv(auv), .buckFeedbackUv(buv),
        .chargePumpUv(sup[0]), .supplyOverLow(sup[1]), .supplyOverHigh(sup[2]),
        .buckOverCurrent(boc), .fetOverCurrent({6{fOc}}), .phaseOverLockLimit({3{cLk}}),
        .adcValid(1'b1), .adcPhaseA({12{sLk}}), .adcPhaseB({12{sLk}}), .adcPhaseC({12{sLk}}),
        .faultPinInN(pinN), .faultPinOutN(outN), .faultPinOeN(oeN), .fetsOff(fOff),
        .lowSideOn(lowOn), .highSideOn(highOn), .chargePumpEnable(cpEn), .buckHiZ(hiZ),
        .controllerEnable(ctlEn), .resetRequest(rstReq), .fetOvercurrentLevel(ocLvl),
        .comparatorLockCurrentLimit(lkLim));
    mdfp_host_model mdfp_host_model_i (.faultPinOutN(outN), .faultPinOeN(oeN),
        .pinLevelN(pinN));
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        cmpCount++;
        if (got !== exp) $display("[ERR] %s expected %h seen %h", nm, exp, got);
        nFail += int'(got !== exp);
    endtask : chk
    task automatic acc(input logic r, input logic [7:0] a, input logic [31:0] d, m);
        {addr, wd} <= {a, d};
        {rdS, wrS} <= {r, !r};
        @(posedge clock);
        {rdS, wrS} <= 2'b00;
        @(posedge clock);
        if (r) chk("rdata", rdat & m, d);
    endtask : acc
    task automatic final_report(input int late);
        nFail += late;
        $display("compares %0d mismatches %0d", cmpCount, nFail);
        if (nFail == 0 && cmpCount > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : final_report
    task automatic t_supply;
        sup <= 3'h1;
        repeat (6) @(posedge clock);
        chk("cpuv", {fOff, oeN}, 2'b10);
        sup <= 3'h2;
        buv <= 1'b1;
        repeat (6) @(posedge clock);
        acc(1, STAT_OFS, 32'h002d, 32'h802f);
        buv <= 1'b0;
        // the low comparator still trips: only the enable keeps the bridge running
        acc(0, CFG_OFS, 32'h0, 0);
        @(posedge clock);
        chk("ov off", {fOff, oeN}, 2'h1);
        $display("supply test done");
    endtask : t_supply
    task automatic t_ocp;
        acc(0, DEG_OFS, 32'h3, 0);
        acc(0, CFG_OFS, 32'h25c07, 0);
        chk("levels", {lkLim, ocLvl}, 8'h97);
        acc(1, CFG_OFS, 32'h25c07, 32'hffffffff);
        // three cycles only reach the filter count, one short of tripping
        fOc <= 1'b1;
        repeat (3) @(posedge clock);
        fOc <= 1'b0;
        repeat (6) @(posedge clock);
        chk("glitch", fOff, 0);
        fOc <= 1'b1;
        repeat (10) @(posedge clock);
        fOc <= 1'b0;
        acc(1, STAT_OFS, 32'h7e11, 32'hfe13);
        repeat (25) @(posedge clock);
        acc(1, STAT_OFS, 32'hfe10, 32'hfe13);
        $display("overcurrent test done");
    endtask : t_ocp
    task automatic t_lock;
        logic [2:0] m;
        logic [3:0] e;
        acc(0, DEG_OFS, 32'h0, 0);
        for (int k = 0; k < 16; k++) begin
            m = k[2:0];
            e = {m % 3 == 0 && m < 6, m % 3 == 1 && m < 6, m % 3 == 2 && m < 6, m == 7};
            acc(0, CFG_OFS, 32'h3f3 ^ ({29'h0, ~m} << (k[3] ? 7 : 4)), 0);
            {cLk, sLk} <= k[3] ? 2'b01 : 2'b10;
            repeat (8) @(posedge clock);
            chk("action", {fOff, lowOn, highOn, oeN}, e);
            {cLk, sLk} <= 2'b00;
            repeat (40) @(posedge clock);
            chk("recover", oeN, m > 2 && m != 6);
            acc(0, CTRL_OFS, 32'h1, 0);
        end
        auv <= 1'b1;
        repeat (6) @(posedge clock);
        chk("analog", {fOff, cpEn, ctlEn, rstReq}, 4'h9);
        $display("lock test done");
    endtask : t_lock
    task automatic t_buck;
        rst <= 1'b1;
        {auv, sup} <= 4'h0;
        repeat (2) @(posedge clock);
        chk("reset", {fOff, cpEn, ctlEn, rstReq, hiZ, oeN}, 6'h39);
        // released with the enable low: nothing may move, not even the synchronisers
        {rst, ceIn, boc} <= 3'h1;
        repeat (20) @(posedge clock);
        chk("frozen", {fOff, hiZ}, 2'h2);
        ceIn <= 1'b1;
        repeat (14) @(posedge clock);
        chk("buck early", hiZ, 0);
        @(posedge clock);
        chk("buck trip", {hiZ, rstReq, fOff}, 3'h7);
        boc <= 1'b0;
        $display("buck test done");
    endtask : t_buck
    initial forever #5 clock = ~clock;
    initial begin
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        t_supply();
        t_ocp();
        t_lock();
        t_buck();
        final_report(0);
    end
    initial #100us final_report(1);
endmodule : mdfp_fault_protect_tb
